// [rtl/rmp_map.svh]
`ifndef RMP_MAP_SVH
`define RMP_MAP_SVH

// region count, sub-region count and size limits (log2 of bytes)
`define RMP_NUM_REGIONS    8
`define RMP_SUB_COUNT      8
`define RMP_GRANULE_LOG2   5'h05
`define RMP_SUB_MIN_LOG2   5'h08

// register offsets (byte addresses)
`define RMP_OFS_CTRL       12'h000
`define RMP_OFS_STATUS     12'h004
`define RMP_OFS_CLEAR      12'h008
`define RMP_OFS_IRQ_EN     12'h00C
`define RMP_OFS_FAULT_ADDR 12'h010
`define RMP_OFS_FAULT_INFO 12'h014
`define RMP_OFS_REGION     12'h040
`define RMP_OFS_RGN_CTRL   12'h004

// control register fields
`define RMP_CTRL_EN        0
`define RMP_CTRL_BG        1

// region control fields
`define RMP_RC_EN          0
`define RMP_RC_SIZE_LO     1
`define RMP_RC_SIZE_HI     5
`define RMP_RC_SRD_LO      8
`define RMP_RC_SRD_HI      15
`define RMP_RC_AP_LO       16
`define RMP_RC_AP_HI       17
`define RMP_RC_XN          18
`define RMP_RC_ATTR_LO     24
`define RMP_RC_ATTR_HI     31

// status bits
`define RMP_ST_PERM        0
`define RMP_ST_FETCH       1
`define RMP_ST_NOMATCH     2
`define RMP_ST_W           3

// reset values
`define RMP_CTRL_RST       32'h0000_0000
`define RMP_RC_RST         32'h0000_0000
`define RMP_BG_ATTR        8'h00
`define RMP_BG_ID          4'hF

`endif

// [rtl/rmp_pkg.sv]
package rmp_pkg;

    // access permission of a region
    typedef enum logic [1:0]
    {
        RMP_AP_NONE = 2'b00,
        RMP_AP_RO   = 2'b01,
        RMP_AP_RW   = 2'b10,
        RMP_AP_RSV  = 2'b11
    } rmp_ap_t;

    // one region's settings
    typedef struct packed
    {
        logic [31:0] base;
        logic        en;
        logic [4:0]  size;
        logic [7:0]  srd;
        rmp_ap_t     ap;
        logic        xn;
        logic [7:0]  attr;
    } rmp_rcfg_t;

endpackage

// [rtl/rmp_reg_if.sv]
`timescale 1ns/10ps
interface rmp_reg_if;
    logic        wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic        wr_ok;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;

    modport bus
    (
        output wr_en, wr_addr, wr_data, rd_addr,
        input  wr_ok, rd_data, rd_ok
    );
    modport regs
    (
        input  wr_en, wr_addr, wr_data, rd_addr,
        output wr_ok, rd_data, rd_ok
    );
endinterface

// [rtl/rmp_region.sv]
`timescale 1ns/10ps
`include "rmp_map.svh"
module rmp_region
    import rmp_pkg::*;
(
    input  wire rmp_rcfg_t   cfg,  // region settings
    input  wire logic [31:0] addr, // access address
    output logic             hit   // region covers the address
);
    logic [31:0] diff;
    logic [31:0] span;
    logic [31:0] sub_sh;
    logic [2:0]  sub_idx;
    logic        size_ok;
    logic        in_range;
    logic        sub_on;

    // range match over the naturally aligned block of 2^size bytes; size 31 matches the whole address space
    assign diff     = addr ^ cfg.base;
    assign span     = diff >> cfg.size;
    assign size_ok  = cfg.size >= `RMP_GRANULE_LOG2;
    assign in_range = (cfg.size == 5'h1F) || (span == 32'h0000_0000);
    // sub-region index is the top three bits inside the region
    assign sub_sh   = addr >> (cfg.size - 5'h03);
    assign sub_idx  = sub_sh[2:0];
    // small regions ignore the disable mask
    assign sub_on   = (cfg.size < `RMP_SUB_MIN_LOG2)
                      || !cfg.srd[sub_idx];
    assign hit      = cfg.en && size_ok && in_range && sub_on;
endmodule

// [rtl/rmp_axil.sv]
`timescale 1ns/10ps
module rmp_axil
(
    input  wire logic        clk,     // system clock
    input  wire logic        rstn,    // async reset, active low
    input  wire logic [11:0] awaddr,  // write address
    input  wire logic        awvalid, // write address valid
    output logic             awready, // write address ready
    input  wire logic [31:0] wdata,   // write data
    input  wire logic [3:0]  wstrb,   // byte strobes
    input  wire logic        wvalid,  // write data valid
    output logic             wready,  // write data ready
    output logic [1:0]       bresp,   // write response
    output logic             bvalid,  // write response valid
    input  wire logic        bready,  // write response ready
    input  wire logic [11:0] araddr,  // read address
    input  wire logic        arvalid, // read address valid
    output logic             arready, // read address ready
    output logic [31:0]      rdata,   // read data
    output logic [1:0]       rresp,   // read response
    output logic             rvalid,  // read data valid
    input  wire logic        rready,  // read data ready
    rmp_reg_if.bus           rif      // register file side
);
    logic        aw_full;
    logic        w_full;
    logic [11:0] aw_q;
    logic [31:0] w_q;
    logic        do_wr;

    // register file strobe once both halves are held
    assign do_wr       = aw_full && w_full && !bvalid;
    assign rif.wr_en   = do_wr;
    assign rif.wr_addr = aw_q;
    assign rif.wr_data = w_q;
    assign rif.rd_addr = araddr;

    // both halves caught in either order; ready reopens with the response
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_q    <= 12'h000;
            w_q     <= 32'h0000_0000;
            awready <= 1'b1;
            wready  <= 1'b1;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_full <= 1'b1;
                aw_q    <= awaddr;
                awready <= 1'b0;
            end
            else if (do_wr)
                aw_full <= 1'b0;
            if (wvalid && wready)
            begin
                w_full <= 1'b1;
                w_q    <= wdata;  // strobes ignored: word registers
                wready <= 1'b0;
            end
            else if (do_wr)
                w_full <= 1'b0;
            if (bvalid && bready)
            begin
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bvalid <= 1'b0;
            bresp  <= 2'b00;
        end
        else if (do_wr)
        begin
            bvalid <= 1'b1;
            bresp  <= rif.wr_ok ? 2'b00 : 2'b10;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // read data one cycle after the address is taken
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= 2'b00;
            arready <= 1'b1;
        end
        else if (arvalid && arready)
        begin
            rvalid  <= 1'b1;
            rdata   <= rif.rd_data;
            rresp   <= rif.rd_ok ? 2'b00 : 2'b10;
            arready <= 1'b0;
        end
        else if (rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

// [rtl/rmp_top.sv]
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`include "rmp_map.svh"

// Behaviour
// - eight programmable regions, numbered zero to seven
// - sub-region split only for regions of 256 bytes or more
// - each of eight sub-regions disabled by its own mask bit
// - smallest granule is 32 bytes; 256 bytes gives eight of them
// - background region, id minus one, applies when nothing matches
// - highest-numbered matching region wins
// - priority order is fixed in hardware
// - regions may overlap or nest; priority resolves it
// - permission per region: none, read only, read and write
// - per-region fetch guard forbids instruction fetches
// - every region keeps its own settings
// - selected region's attributes are output with the access
module rmp_top
    import rmp_pkg::*;
#(
    parameter int NREG = `RMP_NUM_REGIONS  // number of regions
)
(
    input  wire logic        clk,          // system clock
    input  wire logic        rstn,         // async reset, active low
    input  wire logic [11:0] awaddr,       // axi write address
    input  wire logic        awvalid,      // axi write address valid
    output logic             awready,      // axi write address ready
    input  wire logic [31:0] wdata,        // axi write data
    input  wire logic [3:0]  wstrb,        // axi write strobes
    input  wire logic        wvalid,       // axi write data valid
    output logic             wready,       // axi write data ready
    output logic [1:0]       bresp,        // axi write response
    output logic             bvalid,       // axi write response valid
    input  wire logic        bready,       // axi write response ready
    input  wire logic [11:0] araddr,       // axi read address
    input  wire logic        arvalid,      // axi read address valid
    output logic             arready,      // axi read address ready
    output logic [31:0]      rdata,        // axi read data
    output logic [1:0]       rresp,        // axi read response
    output logic             rvalid,       // axi read data valid
    input  wire logic        rready,       // axi read data ready
    input  wire logic        acc_valid,    // core access request
    input  wire logic [31:0] acc_addr,     // access address
    input  wire logic        acc_write,    // access is a write
    input  wire logic        acc_fetch,    // access is an instruction fetch
    output logic             resp_valid,   // check result pulse
    output logic             resp_allow,   // access may complete
    output logic             resp_fault,   // access blocked, fault
    output logic [3:0]       resp_region,  // selected region, F = default
    output logic [7:0]       resp_attr,    // selected memory attributes
    output logic [31:0]      resp_addr,    // address of the checked access
    output logic             irq           // interrupt, level
);
    localparam logic [2:0] ST_ALL = 3'h7;

    rmp_reg_if rif ();

    logic [31:0]      ctrl;
    logic [2:0]       status;
    logic [2:0]       irq_en;
    logic [31:0]      fault_addr;
    logic [5:0]       fault_info;
    rmp_rcfg_t        rcfg [NREG];
    logic [NREG-1:0]  hits;
    logic             any_hit;
    logic [2:0]       win;
    rmp_rcfg_t        sel;
    logic             mpu_on;
    logic             bg_on;
    logic             perm_bad;
    logic             fetch_bad;
    logic             nomatch_bad;
    logic             bad;
    logic [3:0]       sel_id;
    logic [7:0]       sel_attr;
    logic [2:0]       ev;
    logic [2:0]       clr;
    logic [2:0]       next_status;
    logic             in_rgn;
    logic [2:0]       rgn_idx;
    logic             rgn_ctl;
    logic             wr_in_rgn;
    logic [2:0]       wr_idx;
    logic             wr_ctl;

    // bus slave
    rmp_axil u_axil
    (
        .clk     (clk),
        .rstn    (rstn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rif     (rif.bus)
    );

    // one matcher per region, each fed only its own settings
    for (genvar g = 0; g < NREG; g++)
    begin : g_rgn
        rmp_region u_rgn
        (
            .cfg  (rcfg[g]),
            .addr (acc_addr),
            .hit  (hits[g])
        );
    end

    // fixed priority: scan upward so the highest hit is kept last
    always_comb
    begin
        win = 3'h0;
        for (int i = 0; i < NREG; i++)
            if (hits[i])
                win = 3'(i);
    end

    // selection and permission check
    assign any_hit     = |hits;
    assign sel         = rcfg[win];
    assign mpu_on      = ctrl[`RMP_CTRL_EN];
    assign bg_on       = ctrl[`RMP_CTRL_BG];
    assign sel_id      = any_hit ? {1'b0, win} : `RMP_BG_ID;
    assign sel_attr    = any_hit ? sel.attr : `RMP_BG_ATTR;
    assign perm_bad    = mpu_on && any_hit
                         && ((sel.ap == RMP_AP_NONE)
                         || (sel.ap == RMP_AP_RSV)
                         || (acc_write && sel.ap != RMP_AP_RW));
    assign fetch_bad   = mpu_on && any_hit && acc_fetch
                         && sel.xn;
    assign nomatch_bad = mpu_on && !any_hit && !bg_on;
    assign bad         = perm_bad || fetch_bad || nomatch_bad;

    // result of each access, one cycle after the request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            resp_valid  <= 1'b0;
            resp_allow  <= 1'b0;
            resp_fault  <= 1'b0;
            resp_region <= `RMP_BG_ID;
            resp_attr   <= `RMP_BG_ATTR;
            resp_addr   <= 32'h0000_0000;
        end
        else
        begin
            resp_valid <= acc_valid;
            resp_allow <= acc_valid && !bad;
            resp_fault <= acc_valid && bad;
            if (acc_valid)
            begin
                resp_region <= sel_id;
                resp_attr   <= sel_attr;
                resp_addr   <= acc_addr;
            end
        end
    end

    // fault events; a new event beats a clear in the same cycle
    assign ev          = acc_valid ? {nomatch_bad, fetch_bad, perm_bad}
                                   : 3'h0;
    assign clr         = (rif.wr_en && rif.wr_addr == `RMP_OFS_CLEAR)
                         ? rif.wr_data[2:0] : 3'h0;
    assign next_status = (status & ~clr) | ev;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status     <= 3'h0;
            irq        <= 1'b0;
            fault_addr <= 32'h0000_0000;
            fault_info <= 6'h00;
        end
        else
        begin
            status <= next_status;
            irq    <= |(next_status & irq_en);
            if (acc_valid && bad)
            begin
                fault_addr <= acc_addr;
                fault_info <= {acc_fetch, acc_write, sel_id};
            end
        end
    end

    // address decode of the region area
    assign in_rgn    = rif.rd_addr[11:6] == 6'(`RMP_OFS_REGION >> 6);
    assign rgn_idx   = rif.rd_addr[5:3];
    assign rgn_ctl   = rif.rd_addr[2];
    assign wr_in_rgn = rif.wr_addr[11:6] == 6'(`RMP_OFS_REGION >> 6);
    assign wr_idx    = rif.wr_addr[5:3];
    assign wr_ctl    = rif.wr_addr[2];

    // register writes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl   <= `RMP_CTRL_RST;
            irq_en <= 3'h0;
            for (int i = 0; i < NREG; i++)
                rcfg[i] <= rmp_rcfg_t'(0);
        end
        else if (rif.wr_en)
        begin
            if (rif.wr_addr == `RMP_OFS_CTRL)
                ctrl <= {30'h0000_0000, rif.wr_data[1:0]};
            if (rif.wr_addr == `RMP_OFS_IRQ_EN)
                irq_en <= rif.wr_data[2:0] & ST_ALL;
            if (wr_in_rgn && !wr_ctl)
                rcfg[wr_idx].base <= {rif.wr_data[31:5], 5'h00};
            if (wr_in_rgn && wr_ctl)
            begin
                rcfg[wr_idx].en   <= rif.wr_data[`RMP_RC_EN];
                rcfg[wr_idx].size <=
                    rif.wr_data[`RMP_RC_SIZE_HI:`RMP_RC_SIZE_LO];
                rcfg[wr_idx].srd  <=
                    rif.wr_data[`RMP_RC_SRD_HI:`RMP_RC_SRD_LO];
                rcfg[wr_idx].ap   <=
                    rmp_ap_t'(rif.wr_data[`RMP_RC_AP_HI:`RMP_RC_AP_LO]);
                rcfg[wr_idx].xn   <= rif.wr_data[`RMP_RC_XN];
                rcfg[wr_idx].attr <=
                    rif.wr_data[`RMP_RC_ATTR_HI:`RMP_RC_ATTR_LO];
            end
        end
    end

    // map check for writes
    assign rif.wr_ok = wr_in_rgn
                       || rif.wr_addr == `RMP_OFS_CTRL
                       || rif.wr_addr == `RMP_OFS_STATUS
                       || rif.wr_addr == `RMP_OFS_CLEAR
                       || rif.wr_addr == `RMP_OFS_IRQ_EN
                       || rif.wr_addr == `RMP_OFS_FAULT_ADDR
                       || rif.wr_addr == `RMP_OFS_FAULT_INFO;

    // register reads; unmapped reads answer zero with an error
    always_comb
    begin
        rif.rd_data = 32'h0000_0000;
        rif.rd_ok   = 1'b1;
        if (in_rgn && !rgn_ctl)
            rif.rd_data = rcfg[rgn_idx].base;
        else if (in_rgn)
            rif.rd_data = {rcfg[rgn_idx].attr, 5'h00, rcfg[rgn_idx].xn,
                           rcfg[rgn_idx].ap, rcfg[rgn_idx].srd, 2'h0,
                           rcfg[rgn_idx].size, rcfg[rgn_idx].en};
        else
            unique case (rif.rd_addr)
                `RMP_OFS_CTRL:       rif.rd_data = ctrl;
                `RMP_OFS_STATUS:     rif.rd_data = {29'h0000_0000, status};
                `RMP_OFS_CLEAR:      rif.rd_data = 32'h0000_0000;
                `RMP_OFS_IRQ_EN:     rif.rd_data = {29'h0000_0000, irq_en};
                `RMP_OFS_FAULT_ADDR: rif.rd_data = fault_addr;
                `RMP_OFS_FAULT_INFO: rif.rd_data = {26'h000_0000,
                                                    fault_info};
                default:             rif.rd_ok   = 1'b0;
            endcase
    end
endmodule

// [dv/rmp_top_asserts.sv]
`timescale 1ns/10ps
module rmp_top_asserts
(
    input wire logic        clk,         // system clock
    input wire logic        rstn,        // async reset, active low
    input wire logic        awvalid,     // write address valid
    input wire logic        awready,     // write address ready
    input wire logic        wvalid,      // write data valid
    input wire logic        wready,      // write data ready
    input wire logic        bvalid,      // write response valid
    input wire logic        arvalid,     // read address valid
    input wire logic        arready,     // read address ready
    input wire logic        rvalid,      // read data valid
    input wire logic        acc_valid,   // access request
    input wire logic [31:0] acc_addr,    // access address
    input wire logic        resp_valid,  // check result pulse
    input wire logic        resp_allow,  // access may complete
    input wire logic        resp_fault,  // access blocked
    input wire logic [3:0]  resp_region, // selected region
    input wire logic [7:0]  resp_attr,   // selected attributes
    input wire logic [31:0] resp_addr    // checked address
);
    default clocking dclk @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // both write channels taken at one edge
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    // response two cycles on, not earlier
    sequence s_wr_answer;
        !bvalid ##1 bvalid;
    endsequence
    sequence s_rd_taken;
        arvalid && arready;
    endsequence

    a_resp_one_cycle: assert property (acc_valid |=> resp_valid)
        else $error("no check result one cycle after access");
    a_resp_no_spur: assert property (!acc_valid |=> !resp_valid)
        else $error("check result without an access");
    a_allow_xor_fault: assert property (resp_valid |-> resp_allow ^ resp_fault)
        else $error("allow and fault not exclusive");
    a_flags_idle: assert property (!resp_valid |-> !(resp_allow || resp_fault))
        else $error("allow or fault outside result pulse");
    a_addr_capture: assert property (acc_valid |=> resp_addr == $past(acc_addr))
        else $error("result address differs from access");
    a_result_held: assert property (!acc_valid |=>
        $stable(resp_region) && $stable(resp_attr))
        else $error("region or attributes moved without access");
    a_default_attr: assert property (resp_valid && resp_region == 4'hF
        |-> resp_attr == 8'h00)
        else $error("default region with nonzero attributes");
    a_region_range: assert property (resp_valid
        |-> resp_region <= 4'h7 || resp_region == 4'hF)
        else $error("region number out of range");
    a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write response not two cycles after handshake");
    a_read_answer: assert property (s_rd_taken |=> rvalid && !arready)
        else $error("read data not one cycle after address");
endmodule

bind rmp_top rmp_top_asserts u_chk
(
    .clk, .rstn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid,
    .arready, .rvalid, .acc_valid, .acc_addr, .resp_valid, .resp_allow,
    .resp_fault, .resp_region, .resp_attr, .resp_addr
);

// [dv/rmp_core_model.sv]
`timescale 1ns/10ps
module rmp_core_model
(
    input  wire logic   clk,       // system clock
    output logic        acc_valid, // access request
    output logic [31:0] acc_addr,  // access address
    output logic        acc_write, // write flag
    output logic        acc_fetch  // fetch flag
);
    // quiet core at time zero
    initial
    begin
        acc_valid = 1'h0;
        acc_addr  = 32'h0000_0000;
        acc_write = 1'h0;
        acc_fetch = 1'h0;
    end

    // one request, launched right after an edge
    task automatic drive(input logic [31:0] a, input logic w, input logic f);
        @(posedge clk);
        acc_valid <= 1'h1;
        acc_addr  <= a;
        acc_write <= w;
        acc_fetch <= f;
    endtask

    // lines wander when idle so stale values are never trusted
    task automatic idle();
        @(posedge clk);
        acc_valid <= 1'h0;
        acc_addr  <= ~acc_addr;
        acc_write <= ~acc_write;
        acc_fetch <= ~acc_fetch;
    endtask
endmodule

// [dv/test_region_memory_protection.sv]
`timescale 1ns/10ps
module test_region_memory_protection
    import rmp_pkg::*;
;
    logic        clk = 1'h0, rstn = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, acc_addr, rdata, resp_addr;
    logic [3:0]  wstrb = 4'hF, resp_region;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        acc_valid, acc_write, acc_fetch, irq;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        resp_valid, resp_allow, resp_fault;
    logic [1:0]  bresp, rresp;
    logic [7:0]  resp_attr;
    logic [14:0] p_exp;
    logic        pend = 1'h0;
    int          bad_count = 0, n_compared = 0;

    rmp_top dut
    (
        .clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .acc_valid, .acc_addr,
        .acc_write, .acc_fetch, .resp_valid, .resp_allow, .resp_fault,
        .resp_region, .resp_attr, .resp_addr, .irq
    );
    rmp_core_model core
    (
        .clk, .acc_valid, .acc_addr, .acc_write, .acc_fetch
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // axi write: both channels offered together, held until taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid)
            begin
                bready <= 1'h0;
                chk(32'(bresp), 32'(er));
            end
        end
        while (awvalid || wvalid || bready);
    endtask

    // axi read: address held until taken, data taken with rvalid
    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid)
            begin
                rready <= 1'h0;
                chk(rdata, ed);
                chk(32'(rresp), 32'(er));
            end
        end
        while (rready);
    endtask

    // region control word: attr, no-fetch, perm, sub-disable, size, enable
    function automatic logic [31:0] rc(input logic [4:0] sz,
        input logic [7:0] sd, input rmp_ap_t ap, input logic xn,
        input logic [7:0] at);
        return {at, 5'h00, xn, ap, sd, 2'h0, sz, 1'h1};
    endfunction

    task automatic rgn(input logic [11:0] n, input logic [31:0] b,
                       input logic [31:0] c);
        wr(12'h040 + 12'h008 * n, b, 2'h0);
        wr(12'h044 + 12'h008 * n, c, 2'h0);
    endtask

    // result of the previous access shows one cycle after it was taken
    task automatic check_pend();
        #1;
        if (pend)
            chk(32'({resp_valid, resp_allow, resp_fault, resp_region,
                     resp_attr}), 32'(p_exp));
    endtask

    // back-to-back accesses: issue one, check the one before
    task automatic acc(input logic [31:0] a, input logic w, input logic f,
        input logic [3:0] er, input logic ef, input logic [7:0] ea);
        core.drive(a, w, f);
        check_pend();
        pend  = 1'h1;
        p_exp = {1'h1, ~ef, ef, er, ea};
    endtask

    task automatic acc_end();
        core.idle();
        check_pend();
        pend = 1'h0;
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(irq), 32'(e));
    endtask

    // watchdog cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        rd(12'h000, 32'h0000_0000, 2'h0);
        acc(32'h0000_1000, 1'h0, 1'h0, 4'hF, 1'h0, 8'h00);
        acc_end();
        rgn(12'h000, 32'h0000_0000, rc(5'h10, 8'h00, RMP_AP_RW, 1'h0, 8'h10));
        rgn(12'h003, 32'h0000_101F, rc(5'h08, 8'h04, RMP_AP_RO, 1'h0, 8'h33));
        rgn(12'h007, 32'h0000_1000, rc(5'h05, 8'hFF, RMP_AP_NONE, 1'h0, 8'h77));
        rgn(12'h005, 32'h2000_0000, rc(5'h0C, 8'h00, RMP_AP_RW, 1'h1, 8'h55));
        rgn(12'h006, 32'h6000_0000, rc(5'h05, 8'h00, RMP_AP_RSV, 1'h0, 8'h66));
        rd(12'h058, 32'h0000_1000, 2'h0);
        rd(12'h05C, rc(5'h08, 8'h04, RMP_AP_RO, 1'h0, 8'h33), 2'h0);
        wr(12'h000, 32'h0000_0003, 2'h0);
        acc(32'h0000_1000, 1'h0, 1'h0, 4'h7, 1'h1, 8'h77);
        acc(32'h0000_1020, 1'h0, 1'h0, 4'h3, 1'h0, 8'h33);
        acc(32'h0000_1020, 1'h1, 1'h0, 4'h3, 1'h1, 8'h33);
        acc(32'h0000_1040, 1'h0, 1'h0, 4'h0, 1'h0, 8'h10);
        acc(32'h0000_1040, 1'h1, 1'h0, 4'h0, 1'h0, 8'h10);
        acc(32'h2000_0000, 1'h0, 1'h1, 4'h5, 1'h1, 8'h55);
        acc(32'h2000_0004, 1'h1, 1'h0, 4'h5, 1'h0, 8'h55);
        acc(32'h6000_0000, 1'h0, 1'h0, 4'h6, 1'h1, 8'h66);
        acc(32'h4000_0000, 1'h0, 1'h0, 4'hF, 1'h0, 8'h00);
        acc_end();
        irq_is(1'h0);
        rd(12'h004, 32'h0000_0003, 2'h0);
        wr(12'h00C, 32'h0000_0007, 2'h0);
        irq_is(1'h1);
        wr(12'h008, 32'h0000_0003, 2'h0);
        irq_is(1'h0);
        rd(12'h004, 32'h0000_0000, 2'h0);
        wr(12'h000, 32'h0000_0001, 2'h0);
        acc(32'h4000_0000, 1'h1, 1'h0, 4'hF, 1'h1, 8'h00);
        acc_end();
        irq_is(1'h1);
        rd(12'h010, 32'h4000_0000, 2'h0);
        rd(12'h014, 32'h0000_001F, 2'h0);
        wr(12'h00C, 32'h0000_0003, 2'h0);
        irq_is(1'h0);
        wr(12'h008, 32'h0000_0004, 2'h0);
        rd(12'h004, 32'h0000_0000, 2'h0);
        // unmapped and read-only places
        rd(12'h800, 32'h0000_0000, 2'h2);
        wr(12'h800, 32'hFFFF_FFFF, 2'h2);
        wr(12'h004, 32'hFFFF_FFFF, 2'h0);
        rd(12'h004, 32'h0000_0000, 2'h0);
        rd(12'h008, 32'h0000_0000, 2'h0);
        summarize();
    end
endmodule
